// File: dual_clock_fifo_params.svh
// Purpose: Constants for the 64 x 36 FIFO control block
// Assumes: Included by bare name, one copy per compile unit
// Notes:   Flag offset codes are in FIFO-count width (7 bits)
`ifndef DUAL_CLOCK_FIFO_PARAMS_SVH
`define DUAL_CLOCK_FIFO_PARAMS_SVH

`define FIFO_DEPTH       64
`define FIFO_WIDTH       36
`define OFFSET_SEL_HH    7'h10
`define OFFSET_SEL_HL    7'h0C
`define OFFSET_SEL_LH    7'h08
`define OFFSET_SEL_LL    7'h04
`define RESET_OFFSET     7'h04
`define BYTE_BITS        9
`define SIZE_MAILBOX     2'h3

`endif

// File: dual_clock_fifo_pkg.sv
// Purpose: Types shared by the FIFO control block
// Assumes: Nothing is imported; users write the package name
// Notes:   Release sequencer states are one-hot
package dual_clock_fifo_pkg;

    // Sequence after reset release
    typedef enum logic [2:0] {
        REL_HOLD = 3'b001,
        REL_WAIT = 3'b010,
        REL_RUN  = 3'b100
    } rel_state_t;

    typedef logic [1:0] bus_size_t;

endpackage

// File: dual_clock_fifo_reset_write_read.sv
// Purpose: Reset, flag, transfer and mailbox control of a 64 x 36 FIFO
// Assumes: Both ports sampled on sys_clk_i; inputs synchronous to it
// Notes:   Data buses are split into input, output and output enable
`include "dual_clock_fifo_params.svh"
`timescale 1ns/100ps
`default_nettype none

module dual_clock_fifo_reset_write_read #(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int WIDTH = `FIFO_WIDTH
) (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               offset_select_lo_i,
    input  wire logic               offset_select_hi_i,
    input  wire logic               odd_even_i,
    input  wire logic               port_a_select_n_i,
    input  wire logic               port_a_write_not_read_i,
    input  wire logic               port_a_transfer_enable_i,
    input  wire logic               port_a_mailbox_select_i,
    input  wire logic               port_a_parity_generate_i,
    input  wire logic [WIDTH-1:0]   port_a_bus_i,
    output logic      [WIDTH-1:0]   port_a_bus_o,
    output logic                    port_a_bus_oe_o,
    input  wire logic               port_b_select_n_i,
    input  wire logic               port_b_write_not_read_i,
    input  wire logic               port_b_transfer_enable_i,
    input  wire logic               bus_size_sel_lo_i,
    input  wire logic               bus_size_sel_hi_i,
    input  wire logic               port_b_parity_generate_i,
    input  wire logic [WIDTH-1:0]   port_b_bus_i,
    output logic      [WIDTH-1:0]   port_b_bus_o,
    output logic                    port_b_bus_oe_o,
    output logic                    full_flag_n_o,
    output logic                    empty_flag_n_o,
    output logic                    almost_full_n_o,
    output logic                    almost_empty_n_o,
    output logic                    a_to_b_mailbox_full_n_o,
    output logic                    b_to_a_mailbox_full_n_o,
    output logic                    port_a_parity_error_n_o,
    output logic                    port_b_parity_error_n_o
);

    localparam int PW = $clog2(DEPTH) + 1;

    // Refuse shapes the logic cannot serve
    if (WIDTH != 4 * `BYTE_BITS || DEPTH < 32 ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_shape
        $error("FIFO needs WIDTH 36 and power-of-two DEPTH of 32 or more");
    end

    // Byte tops replaced by generated parity
    function automatic logic [WIDTH-1:0] add_parity(
        input logic [WIDTH-1:0] w, input logic odd);
        logic [WIDTH-1:0] r;
        r = w;
        for (int i = 0; i < 4; i++) begin
            r[i*`BYTE_BITS+8] = (^w[i*`BYTE_BITS +: 8]) ^ odd;
        end
        return r;
    endfunction

    // High when every byte carries correct parity
    function automatic logic parity_ok(
        input logic [WIDTH-1:0] w, input logic odd);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if ((^w[i*`BYTE_BITS +: `BYTE_BITS]) != odd) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    logic [WIDTH-1:0]                mem_q [DEPTH];
    dual_clock_fifo_pkg::rel_state_t rel_q, rel_d;
    logic [PW-1:0]  wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PW-1:0]  count_q, count_d, offset_q, offset_d;
    logic           full_n_q, full_n_d, empty_n_q, empty_n_d;
    logic           afull_n_q, afull_n_d, aempty_n_q, aempty_n_d;
    logic [WIDTH-1:0] a2b_mb_q, a2b_mb_d, b2a_mb_q, b2a_mb_d;
    logic           a2b_full_n_q, a2b_full_n_d, b2a_full_n_q, b2a_full_n_d;
    logic [WIDTH-1:0] a_out_q, a_out_d, b_out_q, b_out_d;
    logic           a_oe_q, a_oe_d, b_oe_q, b_oe_d;
    logic           pea_n_q, pea_n_d, peb_n_q, peb_n_d;
    dual_clock_fifo_pkg::bus_size_t size_lat_q, size_eff_q, size_eff_d;
    logic           fifo_wr, fifo_rd, mb_a_wr, mb_a_rd, mb_b_wr, mb_b_rd;
    logic           b_mail_mode, size_change;

    // Port decode
    always_comb begin
        b_mail_mode = size_lat_q == `SIZE_MAILBOX;
        fifo_wr = !port_a_select_n_i && port_a_write_not_read_i &&
                  port_a_transfer_enable_i && !port_a_mailbox_select_i &&
                  full_n_q;
        mb_a_wr = !port_a_select_n_i && port_a_write_not_read_i &&
                  port_a_transfer_enable_i && port_a_mailbox_select_i;
        mb_a_rd = !port_a_select_n_i && !port_a_write_not_read_i &&
                  port_a_transfer_enable_i && port_a_mailbox_select_i;
        fifo_rd = !port_b_select_n_i && !port_b_write_not_read_i &&
                  port_b_transfer_enable_i && empty_n_q &&
                  !b_mail_mode;
        mb_b_wr = !port_b_select_n_i && port_b_write_not_read_i &&
                  port_b_transfer_enable_i && b_mail_mode;
        mb_b_rd = !port_b_select_n_i && !port_b_write_not_read_i &&
                  port_b_transfer_enable_i && b_mail_mode;
    end

    // Release sequencer, offset load, pointers and flags
    always_comb begin
        rel_d    = rel_q;
        offset_d = offset_q;
        unique case (rel_q)
            dual_clock_fifo_pkg::REL_HOLD: begin
                rel_d = dual_clock_fifo_pkg::REL_WAIT;
                unique case ({offset_select_hi_i, offset_select_lo_i})
                    2'h3: offset_d = `OFFSET_SEL_HH;
                    2'h2: offset_d = `OFFSET_SEL_HL;
                    2'h1: offset_d = `OFFSET_SEL_LH;
                    2'h0: offset_d = `OFFSET_SEL_LL;
                endcase
            end
            dual_clock_fifo_pkg::REL_WAIT: rel_d = dual_clock_fifo_pkg::REL_RUN;
            dual_clock_fifo_pkg::REL_RUN:  rel_d = dual_clock_fifo_pkg::REL_RUN;
            default:                       rel_d = dual_clock_fifo_pkg::REL_HOLD;
        endcase
        wr_ptr_d   = fifo_wr ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d   = fifo_rd ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d    = wr_ptr_d - rd_ptr_d;
        full_n_d   = rel_d == dual_clock_fifo_pkg::REL_RUN &&
                     count_d != PW'(DEPTH);
        empty_n_d  = count_d != '0;
        aempty_n_d = count_d > offset_d;
        afull_n_d  = count_d < PW'(DEPTH) - offset_d;
    end

    // Mailboxes, bus outputs and parity flags
    always_comb begin
        a2b_mb_d     = mb_a_wr ? port_a_bus_i : a2b_mb_q;
        b2a_mb_d     = mb_b_wr ? port_b_bus_i : b2a_mb_q;
        // Set from the writer wins over clear from the reader
        a2b_full_n_d = mb_a_wr ? 1'b0 : (mb_b_rd ? 1'b1 : a2b_full_n_q);
        b2a_full_n_d = mb_b_wr ? 1'b0 : (mb_a_rd ? 1'b1 : b2a_full_n_q);
        a_oe_d = !port_a_select_n_i && !port_a_write_not_read_i;
        b_oe_d = !port_b_select_n_i && !port_b_write_not_read_i;
        // Port A shows B-to-A mail, new mail at once
        a_out_d = port_a_parity_generate_i ?
                  add_parity(b2a_mb_d, odd_even_i) : b2a_mb_d;
        b_out_d = b_out_q;
        if (fifo_rd) begin
            b_out_d = mem_q[rd_ptr_q[PW-2:0]];
            if (port_b_parity_generate_i) begin
                b_out_d = add_parity(b_out_d, odd_even_i);
            end
        end else if (b_oe_d && b_mail_mode) begin
            b_out_d = port_b_parity_generate_i ?
                  add_parity(a2b_mb_d, odd_even_i) : a2b_mb_d;
        end
        size_eff_d  = size_lat_q;
        size_change = size_eff_d != size_eff_q;
        pea_n_d = a_oe_d ? pea_n_q : parity_ok(port_a_bus_i, odd_even_i);
        peb_n_d = size_change ?
                  parity_ok(port_b_bus_i, odd_even_i) : peb_n_q;
    end

    // Storage
    always_ff @(posedge sys_clk_i) begin
        if (fifo_wr) begin
            mem_q[wr_ptr_q[PW-2:0]] <= port_a_bus_i;
        end
    end

    // State registers; reset acts at once, unaligned to clock
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rel_q        <= dual_clock_fifo_pkg::REL_HOLD;
            offset_q     <= `RESET_OFFSET;
            wr_ptr_q     <= '0;
            rd_ptr_q     <= '0;
            count_q      <= '0;
            full_n_q     <= 1'b0;
            empty_n_q    <= 1'b0;
            aempty_n_q   <= 1'b0;
            afull_n_q    <= 1'b1;
            a2b_full_n_q <= 1'b1;
            b2a_full_n_q <= 1'b1;
            a2b_mb_q     <= '0;
            b2a_mb_q     <= '0;
            a_out_q      <= '0;
            b_out_q      <= '0;
            a_oe_q       <= 1'b0;
            b_oe_q       <= 1'b0;
            pea_n_q      <= 1'b1;
            peb_n_q      <= 1'b1;
            size_lat_q   <= '0;
            size_eff_q   <= '0;
        end else begin
            rel_q        <= rel_d;
            offset_q     <= offset_d;
            wr_ptr_q     <= wr_ptr_d;
            rd_ptr_q     <= rd_ptr_d;
            count_q      <= count_d;
            full_n_q     <= full_n_d;
            empty_n_q    <= empty_n_d;
            aempty_n_q   <= aempty_n_d;
            afull_n_q    <= afull_n_d;
            a2b_full_n_q <= a2b_full_n_d;
            b2a_full_n_q <= b2a_full_n_d;
            a2b_mb_q     <= a2b_mb_d;
            b2a_mb_q     <= b2a_mb_d;
            a_out_q      <= a_out_d;
            b_out_q      <= b_out_d;
            a_oe_q       <= a_oe_d;
            b_oe_q       <= b_oe_d;
            pea_n_q      <= pea_n_d;
            peb_n_q      <= peb_n_d;
            size_lat_q   <= {bus_size_sel_hi_i, bus_size_sel_lo_i};
            size_eff_q   <= size_eff_d;
        end
    end

    // Outputs straight from flip-flops
    assign port_a_bus_o            = a_out_q;
    assign port_a_bus_oe_o         = a_oe_q;
    assign port_b_bus_o            = b_out_q;
    assign port_b_bus_oe_o         = b_oe_q;
    assign full_flag_n_o           = full_n_q;
    assign empty_flag_n_o          = empty_n_q;
    assign almost_full_n_o         = afull_n_q;
    assign almost_empty_n_o        = aempty_n_q;
    assign a_to_b_mailbox_full_n_o = a2b_full_n_q;
    assign b_to_a_mailbox_full_n_o = b2a_full_n_q;
    assign port_a_parity_error_n_o = pea_n_q;
    assign port_b_parity_error_n_o = peb_n_q;

    // Checks
    property p_reset_flags;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        rel_q == dual_clock_fifo_pkg::REL_HOLD |->
            !full_n_q && !empty_n_q && !aempty_n_q && afull_n_q &&
            wr_ptr_q == '0 && rd_ptr_q == '0;
    endproperty
    a_reset_flags: assert property (p_reset_flags)
        else $error("flags wrong right after reset");

    property p_full_release;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        rel_q == dual_clock_fifo_pkg::REL_HOLD |->
            !full_n_q ##1 !full_n_q ##1 full_n_q;
    endproperty
    a_full_release: assert property (p_full_release)
        else $error("full flag not high on second edge after release");

    property p_offset_load;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        rel_q == dual_clock_fifo_pkg::REL_HOLD &&
        offset_select_hi_i && !offset_select_lo_i |=>
            offset_q == `OFFSET_SEL_HL ##1 $stable(offset_q);
    endproperty
    a_offset_load: assert property (p_offset_load)
        else $error("offset not loaded from selects at release");

    property p_write_advance;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        fifo_wr |=> wr_ptr_q == $past(wr_ptr_q) + 1'b1;
    endproperty
    a_write_advance: assert property (p_write_advance)
        else $error("write pointer did not advance on write");

    property p_empty_no_read;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !empty_n_q |=> rd_ptr_q == $past(rd_ptr_q);
    endproperty
    a_empty_no_read: assert property (p_empty_no_read)
        else $error("read pointer moved while empty");

    property p_a_drive;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (port_a_select_n_i || port_a_write_not_read_i) |=> !port_a_bus_oe_o;
    endproperty
    a_a_drive: assert property (p_a_drive)
        else $error("port A driven while deselected");

    property p_b_drive;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !port_b_select_n_i && !port_b_write_not_read_i |=> port_b_bus_oe_o;
    endproperty
    a_b_drive: assert property (p_b_drive)
        else $error("port B not driven when selected for read");

    property p_mail_show;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        mb_a_wr && b_oe_d && b_mail_mode && !port_b_parity_generate_i |=>
            port_b_bus_o == $past(port_a_bus_i) && !a_to_b_mailbox_full_n_o;
    endproperty
    a_mail_show: assert property (p_mail_show)
        else $error("new mail not shown on port B");

    property p_peb_hold;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !size_change |=> $stable(port_b_parity_error_n_o);
    endproperty
    a_peb_hold: assert property (p_peb_hold)
        else $error("port B parity flag moved without size change");

    property p_levels;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        rel_q == dual_clock_fifo_pkg::REL_RUN |->
            aempty_n_q == (count_q > offset_q) &&
            afull_n_q == (count_q < PW'(DEPTH) - offset_q);
    endproperty
    a_levels: assert property (p_levels)
        else $error("almost flags disagree with fill level");

endmodule

`default_nettype wire

// File: fifo_host_model.sv
// Purpose: Host on one data bus, resolves the shared wire
// Assumes: Host drives during its own write cycles or while its port is deselected
// Notes:   Undriven wire shows a changing pattern, never a stale value
`timescale 1ns/100ps
`default_nettype none
module fifo_host_model (
    input  wire logic        sys_clk_i,
    input  wire logic        drive_i,
    input  wire logic [35:0] data_i,
    input  wire logic [35:0] dev_bus_i,
    input  wire logic        dev_oe_i,
    output logic      [35:0] wire_o
);
    logic [35:0] last_q = 36'h0;

    // Wire level from both parties' enables
    always_comb begin
        if (drive_i)
            wire_o = data_i;
        else if (dev_oe_i)
            wire_o = dev_bus_i;
        else
            wire_o = ~last_q;
    end

    // Last level, so a released bus toggles every cycle
    always @(posedge sys_clk_i)
        last_q <= wire_o;
endmodule
`default_nettype wire

// File: dual_clock_fifo_reset_write_read_tb.sv
// Purpose: Self-checking bench for the FIFO control block
// Assumes: Both ports on one 25 MHz clock, inputs moved 1 ns after edges
// Notes:   Flags and data are checked one idle edge after each transfer
`timescale 1ns/100ps
`default_nettype none
module dual_clock_fifo_reset_write_read_tb;
    logic        clk = 1'h0, rst_b = 1'h0, fs_lo = 1'h0, fs_hi = 1'h0;
    logic        odd = 1'h0, a_sel_n = 1'h1, a_wnr = 1'h0, a_en = 1'h0;
    logic        a_mb = 1'h0, a_pg = 1'h0, a_drv = 1'h0, b_drv = 1'h0;
    logic        b_pg = 1'h0, b_sel_n = 1'h0, b_wnr = 1'h0, b_en = 1'h0;
    logic        sz_lo = 1'h0, sz_hi = 1'h0;
    logic [35:0] a_dat = 36'h0, b_dat = 36'h0, a_wire, b_wire, a_out, b_out;
    logic        a_oe, b_oe, full_n, empty_n, afull_n, aempty_n;
    logic        mab_n, mba_n, pea_n, peb_n;
    int          n_fail = 0;
    int          samples_checked = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    dual_clock_fifo_reset_write_read dut (
        .sys_clk_i(clk), .rst_b_i(rst_b), .offset_select_lo_i(fs_lo),
        .offset_select_hi_i(fs_hi), .odd_even_i(odd),
        .port_a_select_n_i(a_sel_n), .port_a_write_not_read_i(a_wnr),
        .port_a_transfer_enable_i(a_en), .port_a_mailbox_select_i(a_mb),
        .port_a_parity_generate_i(a_pg), .port_a_bus_i(a_wire),
        .port_a_bus_o(a_out), .port_a_bus_oe_o(a_oe),
        .port_b_select_n_i(b_sel_n), .port_b_write_not_read_i(b_wnr),
        .port_b_transfer_enable_i(b_en), .bus_size_sel_lo_i(sz_lo),
        .bus_size_sel_hi_i(sz_hi), .port_b_parity_generate_i(b_pg),
        .port_b_bus_i(b_wire), .port_b_bus_o(b_out), .port_b_bus_oe_o(b_oe),
        .full_flag_n_o(full_n), .empty_flag_n_o(empty_n),
        .almost_full_n_o(afull_n), .almost_empty_n_o(aempty_n),
        .a_to_b_mailbox_full_n_o(mab_n), .b_to_a_mailbox_full_n_o(mba_n),
        .port_a_parity_error_n_o(pea_n), .port_b_parity_error_n_o(peb_n));
    fifo_host_model host_a (.sys_clk_i(clk), .drive_i(a_drv),
        .data_i(a_dat), .dev_bus_i(a_out), .dev_oe_i(a_oe), .wire_o(a_wire));
    fifo_host_model host_b (.sys_clk_i(clk), .drive_i(b_drv),
        .data_i(b_dat), .dev_bus_i(b_out), .dev_oe_i(b_oe), .wire_o(b_wire));

    // Compare and count
    task automatic chk(input string what, input logic [39:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [35:0] pat(input int n);
        return {n[17:0], ~n[17:0]};
    endfunction

    // Expected word with generated parity in each byte top
    function automatic logic [35:0] par(input logic [35:0] d, input logic o);
        int b;
        par = d;
        for (b = 0; b < 4; b++)
            par[9*b+8] = ^d[9*b +: 8] ^ o;
        return par;
    endfunction

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Reset with offset code, released off the clock edge
    task automatic do_reset(input logic [1:0] fs);
        {fs_hi, fs_lo} = fs;
        #7 rst_b = 1'h0;
        repeat (12) @(posedge clk);
        #1 chk("reset flags", 6'h07,
            {full_n, empty_n, aempty_n, afull_n, mab_n, mba_n});
        #6 rst_b = 1'h1;
        tick();
        chk("full edge 1", 1'h0, full_n);
        tick();
        chk("full edge 2", 1'h1, full_n);
    endtask

    // Port A request held through the taking edge
    task automatic a_op(input logic wnr, mb, input logic [35:0] d);
        {a_sel_n, a_wnr, a_en, a_mb, a_drv} = {1'h0, wnr, 1'h1, mb, wnr};
        a_dat = d;
        tick();
        {a_sel_n, a_wnr, a_en, a_mb, a_drv} = 5'h10;
        tick();
    endtask

    // Port B request, select left low
    task automatic b_op(input logic wnr, input logic [35:0] d);
        {b_wnr, b_en, b_drv} = {wnr, 1'h1, wnr};
        b_dat = d;
        tick();
        {b_wnr, b_en, b_drv} = 3'h0;
        tick();
    endtask

    task automatic flags(input int c, x);
        chk("flags", {c < 64, c > 0, c > x, c < 64 - x},
            {full_n, empty_n, aempty_n, afull_n});
    endtask

    // Fill past full, drain past empty
    task automatic t_levels(input logic [1:0] fs);
        int x;
        int k;
        x = fs == 2'h3 ? 16 : fs == 2'h2 ? 12 : fs == 2'h1 ? 8 : 4;
        do_reset(fs);
        for (k = 1; k <= 65; k++) begin
            a_op(1'h1, 1'h0, pat(k));
            flags(k > 64 ? 64 : k, x);
        end
        for (k = 1; k <= 65; k++) begin
            b_op(1'h0, 36'h0);
            chk("fifo word", pat(k > 64 ? 64 : k), b_out);
            flags(k > 64 ? 0 : 64 - k, x);
        end
        $display("levels test done, offset %0d", x);
    endtask

    // Pointers run past the top of the storage
    task automatic t_wrap();
        int k;
        do_reset(2'h0);
        for (k = 0; k < 150; k++) begin
            a_op(1'h1, 1'h0, pat(k + 300));
            if (k >= 40) begin
                b_op(1'h0, 36'h0);
                chk("wrapped word", pat(k + 260), b_out);
            end
        end
        $display("wrap test done");
    endtask

    // Enables moved freely while transfer enables are low
    task automatic t_oe();
        int i;
        for (i = 0; i < 4; i++) begin
            {a_sel_n, a_wnr, b_sel_n, b_wnr} = {i[1:0], i[1:0]};
            tick();
            tick();
            chk("bus enables", {i == 0, i == 0}, {a_oe, b_oe});
        end
        {a_sel_n, a_wnr, b_sel_n, b_wnr} = 4'h8;
        $display("bus enable test done");
    endtask

    // Mail both ways, parity on mail reads, size flag stability
    task automatic t_mail();
        int o;
        do_reset(2'h1);
        a_op(1'h1, 1'h0, 36'h5A5A5A5A5);
        {sz_hi, sz_lo} = 2'h3;
        tick();
        tick();
        a_op(1'h1, 1'h1, 36'h123456789);
        chk("mail to b", {1'h0, 36'h123456789}, {mab_n, b_out});
        b_pg = 1'h1;
        tick();
        tick();
        chk("mail parity b", par(36'h123456789, 1'h0), b_out);
        b_pg = 1'h0;
        b_op(1'h0, 36'h0);
        chk("mail read", 2'h3, {mab_n, empty_n});
        b_op(1'h1, 36'h813579BDF);
        {a_sel_n, a_wnr} = 2'h0;
        tick();
        tick();
        chk("mail to a", {1'h0, 36'h813579BDF}, {mba_n, a_out});
        for (o = 0; o < 2; o++) begin
            {a_pg, odd} = {1'h1, o[0]};
            tick();
            tick();
            chk("mail parity", par(36'h813579BDF, o[0]), a_out);
        end
        a_pg = 1'h0;
        a_op(1'h0, 1'h1, 36'h0);
        chk("mail a read", 1'h1, mba_n);
        {sz_hi, sz_lo} = 2'h0;
        tick();
        tick();
        b_op(1'h0, 36'h0);
        chk("fifo after mail", 36'h5A5A5A5A5, b_out);
        {b_sel_n, b_drv, sz_lo} = 3'h7;
        b_dat = 36'h000000000;
        for (o = 0; o < 3; o++) begin
            tick();
            tick();
            chk("b parity flag", o == 2, peb_n);
            b_dat = par(36'h000000000, 1'h1);
            if (o == 1)
                sz_lo = 1'h0;
        end
        {b_sel_n, b_drv} = 2'h0;
        $display("mailbox test done");
    endtask

    // Port B parity flag holds while bus size stays put
    task automatic t_size_hold();
        logic held;
        {b_sel_n, b_drv} = 2'h3;
        tick();
        tick();
        held = peb_n;
        for (int k = 0; k < 8; k++) begin
            b_dat = pat(k * 13) ^ {4{9'h100 >> k[0]}};
            tick();
            chk("b parity flag held", held, peb_n);
        end
        {b_sel_n, b_drv} = 2'h0;
        {a_drv, a_dat} = {1'h1, 36'h000000000};
        tick();
        tick();
        chk("a parity flag bad", 1'h0, pea_n);
        a_dat = par(36'h000000000, 1'h1);
        tick();
        tick();
        chk("a parity flag good", 1'h1, pea_n);
        a_drv = 1'h0;
        $display("size hold test done");
    endtask

    // Reset first, before any write
    initial begin
        for (int f = 0; f < 4; f++)
            t_levels(f[1:0]);
        t_wrap();
        t_oe();
        t_mail();
        t_size_hold();
        close_out();
    end

    // Watchdog, about fifteen times the expected run
    initial begin
        #1000000;
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
